// ==== hw/chan_io_mux.sv ====
`timescale 1ns/100ps
`default_nettype none
module chan_io_mux #(
  parameter bit IS_THIRD_BUS = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic input_bus_clock_in,
  input wire logic [16:0] input_bus_data_in,
  input wire logic input_bus_enable_in,
  output chan_io_pkg::sample_t sample_out,
  output logic sample_valid_out,
  input wire chan_io_pkg::chan_out_t [3:0] chan_data_in,
  input wire logic [3:0] chan_new_in,
  output logic [15:0] first_bus_out,
  output logic first_bus_sync_pin_out,
  output logic [15:0] third_bus_out,
  output logic third_bus_sync_pin_out,
  output logic frame_sync_output_out
);
  // ****************************************
  // functions
  // ****************************************
  // byte select within a channel pair
  function automatic logic [7:0] pick_byte(input logic [3:0] code,
    input chan_io_pkg::chan_out_t lo_ch, input chan_io_pkg::chan_out_t hi_ch);
    chan_io_pkg::chan_out_t c;
    c = code[3] ? hi_ch : lo_ch;
    case (code[2:0])
      3'h0: pick_byte = c.i[23:16];
      3'h1: pick_byte = c.i[15:8];
      3'h2: pick_byte = c.i[7:0];
      3'h3: pick_byte = c.q[23:16];
      3'h4: pick_byte = c.q[15:8];
      3'h5: pick_byte = c.q[7:0];
      3'h6: pick_byte = c.agc[15:8];
      default: pick_byte = c.agc[7:0];
    endcase
  endfunction

  // input word decode by swap, mode and format
  function automatic chan_io_pkg::sample_t decode(input logic [16:0] raw,
    input logic [31:0] fmt);
    logic [16:0] w;
    chan_io_pkg::sample_t s;
    w = raw;
    if (fmt[chan_io_pkg::FMT_SWAP])
    begin
      for (int k = 0; k < chan_io_pkg::IN_W; k++)
        w[k] = raw[chan_io_pkg::IN_W - 1 - k];
    end
    case (fmt[chan_io_pkg::FMT_MODE_LO +: 2])
      chan_io_pkg::MODE_FIX16: s = {w[16:1], 3'h0};
      chan_io_pkg::MODE_F14: s = {w[16:3], 2'h0, w[2:0]};
      chan_io_pkg::MODE_F15: s = {w[16:2], 1'h0, 1'h0, w[1:0]};
      default: s = {w[16:1], 2'h0, w[0]};
    endcase
    if (fmt[chan_io_pkg::FMT_OFFSET])
      s.mant[15] = ~s.mant[15];
    decode = s;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] fmt_q;
  logic [31:0] rt01_q;
  logic [31:0] rt23_q;
  logic [31:0] status;
  chan_io_pkg::slot_state_t state_q;
  logic [1:0] slot_q;
  logic arm_q;

  // software writes, reserved bits kept at zero
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fmt_q <= chan_io_pkg::REG_RESET;
      rt01_q <= chan_io_pkg::REG_RESET;
      rt23_q <= chan_io_pkg::REG_RESET;
    end
    else if (ce_in && reg_wr_in)
    begin
      case (reg_addr_in)
        chan_io_pkg::OFF_FORMAT:
          fmt_q <= reg_wdata_in & chan_io_pkg::FORMAT_MASK;
        chan_io_pkg::OFF_ROUTE01:
          rt01_q <= reg_wdata_in & chan_io_pkg::ROUTE01_MASK;
        chan_io_pkg::OFF_ROUTE23:
          rt23_q <= reg_wdata_in & chan_io_pkg::ROUTE23_MASK;
        default: ;
      endcase
    end
  end

  // block state seen by software
  assign status = {27'h0, arm_q, state_q == chan_io_pkg::SLOT_RUN, 1'b0, slot_q};

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 32'h0;
    else if (ce_in)
    begin
      reg_rdata_out <= 32'h0;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          chan_io_pkg::OFF_FORMAT: reg_rdata_out <= fmt_q;
          chan_io_pkg::OFF_ROUTE01: reg_rdata_out <= rt01_q;
          chan_io_pkg::OFF_ROUTE23: reg_rdata_out <= rt23_q;
          chan_io_pkg::OFF_STATUS: reg_rdata_out <= status;
          default: reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // input capture
  // ****************************************
  logic [1:0] ck_s_q;
  logic ck_prev_q;
  logic [16:0] d_s1_q;
  logic [16:0] d_s2_q;
  logic [1:0] en_s_q;
  logic [16:0] raw_q;
  logic raw_en_q;
  logic cap_v_q;
  logic rise;
  logic fall;
  logic use_common;
  logic cap;

  // two-stage synchronisers for the pins
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ck_s_q <= 2'h0;
      ck_prev_q <= 1'b0;
      d_s1_q <= 17'h0;
      d_s2_q <= 17'h0;
      en_s_q <= 2'h0;
    end
    else if (ce_in)
    begin
      ck_s_q <= {ck_s_q[0], input_bus_clock_in};
      ck_prev_q <= ck_s_q[1];
      d_s1_q <= input_bus_data_in;
      d_s2_q <= d_s1_q;
      en_s_q <= {en_s_q[0], input_bus_enable_in};
    end
  end

  // edge selection on the bus clock
  assign rise = ck_s_q[1] & ~ck_prev_q;
  assign fall = ~ck_s_q[1] & ck_prev_q;
  assign use_common = fmt_q[chan_io_pkg::FMT_CLK_SRC] | IS_THIRD_BUS;
  assign cap = use_common | (fmt_q[chan_io_pkg::FMT_INV_CLK] ? fall : rise);

  // captured word, processed on common clock
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      raw_q <= 17'h0;
      raw_en_q <= 1'b0;
      cap_v_q <= 1'b0;
    end
    else if (ce_in)
    begin
      cap_v_q <= cap;
      if (cap)
      begin
        raw_q <= d_s2_q;
        raw_en_q <= en_s_q[1];
      end
    end
  end

  // ****************************************
  // demux delay and gating
  // ****************************************
  logic [2:0] cnt_q;
  logic [2:0] dly;
  logic take;
  logic interp;
  assign dly = fmt_q[chan_io_pkg::FMT_DLY_LO +: 3];
  assign interp = fmt_q[chan_io_pkg::FMT_INTERP];
  assign take = cap_v_q & (raw_en_q ? (dly == 3'h0)
    : (arm_q & (3'(cnt_q + 3'h1) == dly)));

  // samples counted since the last enable
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q <= 3'h0;
      arm_q <= 1'b0;
    end
    else if (ce_in && cap_v_q)
    begin
      if (raw_en_q)
      begin
        cnt_q <= 3'h0;
        arm_q <= (dly != 3'h0);
      end
      else if (arm_q)
      begin
        cnt_q <= 3'(cnt_q + 3'h1);
        arm_q <= ~take;
      end
    end
  end

  // gated or zero-filled output sample
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sample_out <= '0;
      sample_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      sample_valid_out <= take | (interp & cap_v_q);
      if (take)
        sample_out <= decode(raw_q, fmt_q);
      else if (interp && cap_v_q)
        sample_out <= '0;
    end
  end

  // ****************************************
  // output slot counter
  // ****************************************
  logic start;
  logic active;
  assign start = chan_new_in[rt01_q[chan_io_pkg::RT_TSRC_LO +: 2]];
  assign active = (state_q == chan_io_pkg::SLOT_RUN);

  // one slot per cycle from start until slot 3
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= chan_io_pkg::SLOT_IDLE;
      slot_q <= 2'h0;
    end
    else if (ce_in)
    begin
      case (state_q)
        chan_io_pkg::SLOT_IDLE:
          if (start)
          begin
            state_q <= chan_io_pkg::SLOT_RUN;
            slot_q <= 2'h0;
          end
        chan_io_pkg::SLOT_RUN:
          if (start)
            slot_q <= 2'h0;
          else if (slot_q == chan_io_pkg::LAST_SLOT)
            state_q <= chan_io_pkg::SLOT_IDLE;
          else
            slot_q <= 2'(slot_q + 2'h1);
        default: state_q <= chan_io_pkg::SLOT_IDLE;
      endcase
    end
  end

  // ****************************************
  // slot routing
  // ****************************************
  chan_io_pkg::slot_cfg_t cfg;
  logic [15:0] plain;
  logic [15:0] word;
  always_comb
  begin
    case (slot_q)
      2'h0: cfg = rt01_q[10:0];
      2'h1: cfg = rt01_q[chan_io_pkg::RT_HI_SLOT +: 11];
      2'h2: cfg = rt23_q[10:0];
      default: cfg = rt23_q[chan_io_pkg::RT_HI_SLOT +: 11];
    endcase
  end
  assign plain = {pick_byte(cfg.hi, chan_data_in[0], chan_data_in[1]),
    pick_byte(cfg.lo, chan_data_in[0], chan_data_in[1])};
  assign word = plain ^ {16{rt01_q[chan_io_pkg::RT_INVERT]}};

  // buses hold between slots, syncs pulse per slot
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      first_bus_out <= 16'h0;
      third_bus_out <= 16'h0;
      first_bus_sync_pin_out <= 1'b0;
      third_bus_sync_pin_out <= 1'b0;
      frame_sync_output_out <= 1'b0;
    end
    else if (ce_in)
    begin
      frame_sync_output_out <= active & cfg.fsync;
      first_bus_sync_pin_out <= active & cfg.en_first & cfg.fsync;
      third_bus_sync_pin_out <= active & cfg.en_third & cfg.fsync;
      if (active && cfg.en_first)
        first_bus_out <= word;
      if (active && cfg.en_third)
        third_bus_out <= word;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in || !ce_in);

  a_rise_capture: assert property (!use_common && !fmt_q[13] && rise
    |=> cap_v_q) else $error("rising edge not captured");
  a_fall_capture: assert property (!use_common && fmt_q[13] && !fall
    |=> !cap_v_q) else $error("capture off falling edge");
  a_common_capture: assert property (use_common |=> cap_v_q)
    else $error("common clock capture missed");
  a_offset_msb: assert property (take && fmt_q[11] && !fmt_q[4]
    && fmt_q[3:2] == 2'h0 |=> sample_out.mant[15] != $past(raw_q[16]))
    else $error("offset binary msb wrong");
  a_gate_only: assert property (!interp && !take |=> !sample_valid_out)
    else $error("gated input let through");
  a_delay_zero: assert property (cap_v_q && raw_en_q && dly == 3'h0
    |=> sample_valid_out) else $error("aligned sample missed");
  a_swap_msb: assert property (take && fmt_q[4] && !fmt_q[11]
    && fmt_q[3:2] == 2'h0 |=> sample_out.mant[15] == $past(raw_q[0]))
    else $error("swap msb wrong");
  a_fixed_mode: assert property (take && !fmt_q[4] && !fmt_q[11]
    && fmt_q[3:2] == 2'h0 |=> sample_out == {$past(raw_q[16:1]), 3'h0})
    else $error("fixed point decode wrong");
  a_slot_start: assert property (start |=> active && slot_q == 2'h0)
    else $error("slot counter not started");
  a_slot_step: assert property (active && !start && slot_q != 2'h3
    |=> active && slot_q == 2'($past(slot_q) + 2'h1))
    else $error("slot counter did not step");
  a_bus_invert: assert property (active && cfg.en_first
    && rt01_q[27] |=> first_bus_out == ~$past(plain))
    else $error("bus not inverted");
  a_first_sync: assert property (active && cfg.en_first
    |=> first_bus_sync_pin_out == $past(cfg.fsync))
    else $error("first bus sync wrong");
  a_third_quiet: assert property (!active || !cfg.en_third
    |=> !third_bus_sync_pin_out) else $error("third sync stray");

  c_full_frame: cover property (start ##1 active [*4] ##1 !active);
  c_interp: cover property (interp && cap_v_q && !take);
  c_delay_max: cover property (take && dly == 3'h7);
  c_both_buses: cover property (active && cfg.en_first && cfg.en_third);
endmodule
`default_nettype wire

// ==== hw/chan_io_pkg.sv ====
// Operation
// - invert bit set samples input on falling clock edge, else rising edge
// - source bit picks common clock or bus clock; third bus always common
// - processing and output timing run on common clock rising edge
// - format bit set means offset binary, clear means twos complement
// - interpolate bit set interpolates between enables, clear gates input
// - three-bit delay picks sample zero to seven after the enable
// - swap bit reverses input bus so bit 0 becomes most significant
// - two-bit mode decodes fixed 16, float 14/3, 15/2 or 16/1
// - slot counter starts on new sample from channel chosen by field
// - invert bit drives ones complement of all sixteen output bits
// - frame sync asserts during a slot only when its sync bit set
// - first-bus enable routes slot data and sync to first bus
// - third-bus enable routes slot data and sync to third bus
// - high and low byte select codes pick each slot's output bytes
// - second routing register holds slots 2 and 3, same layout
// - codes 0-7 pick lower channel bytes, 8-15 upper channel bytes
package chan_io_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_FORMAT = 12'h100;
  localparam logic [11:0] OFF_ROUTE01 = 12'h101;
  localparam logic [11:0] OFF_ROUTE23 = 12'h102;
  localparam logic [11:0] OFF_STATUS = 12'h1f0;
  localparam logic [31:0] FORMAT_MASK = 32'h0000_ff9c;
  localparam logic [31:0] ROUTE01_MASK = 32'h3fff_07ff;
  localparam logic [31:0] ROUTE23_MASK = 32'h07ff_07ff;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int FMT_INV_CLK = 13;
  localparam int FMT_CLK_SRC = 12;
  localparam int FMT_OFFSET = 11;
  localparam int FMT_INTERP = 10;
  localparam int FMT_DLY_LO = 7;
  localparam int FMT_SWAP = 4;
  localparam int FMT_MODE_LO = 2;
  localparam int RT_TSRC_LO = 28;
  localparam int RT_INVERT = 27;
  localparam int RT_HI_SLOT = 16;
  localparam logic [1:0] MODE_FIX16 = 2'h0;
  localparam logic [1:0] MODE_F14 = 2'h1;
  localparam logic [1:0] MODE_F15 = 2'h2;
  localparam logic [1:0] LAST_SLOT = 2'h3;
  localparam int IN_W = 17;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [15:0] mant;
    logic [2:0] expo;
  } sample_t;
  typedef struct packed {
    logic [23:0] i;
    logic [23:0] q;
    logic [15:0] agc;
  } chan_out_t;
  typedef struct packed {
    logic fsync;
    logic en_third;
    logic en_first;
    logic [3:0] hi;
    logic [3:0] lo;
  } slot_cfg_t;
  typedef enum logic {SLOT_IDLE, SLOT_RUN} slot_state_t;
endpackage

// ==== testbench/conv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// converter input bus model
// ****************************************
module conv_model (
  output logic bus_clk_out,
  output logic [16:0] bus_data_out,
  output logic bus_en_out
);
  // bus parked until the first frame
  initial
  begin
    bus_clk_out = 1'b0;
    bus_data_out = 17'h0;
    bus_en_out = 1'b0;
  end
  // eight words, enable with the first; data moves halfway between edges
  // so that a capture on the wrong edge picks up the previous word
  task automatic frame(input logic [16:0] w [8], input logic inv);
    int k;
    #3;
    for (k = 0; k < 8; k++)
    begin
      bus_clk_out = inv;
      #20;
      bus_data_out = w[k];
      bus_en_out = (k == 0);
      #20;
      bus_clk_out = ~inv;
      #40;
    end
    // released bus shows the inverse, clock parks
    bus_data_out = ~bus_data_out;
    bus_en_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk_in, reset_n_in, ce_in, reg_wr_in, reg_rd_in;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, fmt, r01, r23;
  logic input_bus_clock_in, input_bus_enable_in, sample_valid_out;
  logic [16:0] input_bus_data_in;
  chan_io_pkg::sample_t sample_out;
  chan_io_pkg::chan_out_t [3:0] chan_data_in;
  logic [3:0] chan_new_in;
  logic [15:0] first_bus_out, third_bus_out, last_a, last_c;
  logic first_bus_sync_pin_out, third_bus_sync_pin_out;
  logic frame_sync_output_out, rd_d, mon_on;
  logic [63:0] rq[$], sq[$], fq[$];
  logic [16:0] w [8];
  logic [255:0] cd;
  int num_errors, total_checks, k, j;
  chan_io_mux chan_io_mux_inst (
    .clk_in, .reset_n_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .input_bus_clock_in, .input_bus_data_in,
    .input_bus_enable_in, .sample_out, .sample_valid_out, .chan_data_in,
    .chan_new_in, .first_bus_out, .first_bus_sync_pin_out, .third_bus_out,
    .third_bus_sync_pin_out, .frame_sync_output_out
  );
  conv_model conv_model_inst (
    .bus_clk_out(input_bus_clock_in),
    .bus_data_out(input_bus_data_in),
    .bus_en_out(input_bus_enable_in)
  );
  // 100 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic pop_cmp(ref logic [63:0] q[$], input logic [63:0] g);
    check(q.size() != 0 ? q.pop_front() : 'x, g);
  endtask
  // one compare task per kind of result
  task automatic cmp_reg(input logic [63:0] g);
    pop_cmp(rq, g);
  endtask
  task automatic cmp_sample(input logic [63:0] g);
    pop_cmp(sq, g);
  endtask
  task automatic cmp_slot(input logic [63:0] g);
    pop_cmp(fq, g);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(64'(e));
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic pulse(input logic [1:0] c);
    @(posedge clk_in);
    chan_new_in <= 4'h1 << c;
    @(posedge clk_in);
    chan_new_in <= 4'h0;
  endtask
  // bounded wait until every note has been matched
  task automatic drain;
    int n;
    for (n = 0; n < 400 && rq.size() + sq.size() + fq.size() != 0; n++)
      @(posedge clk_in);
    if (rq.size() + sq.size() + fq.size() != 0)
    begin
      num_errors++;
      close_out;
    end
    else
      repeat (4) @(posedge clk_in);
  endtask
  // expected decode of one input word
  function automatic chan_io_pkg::sample_t dec(input logic [16:0] x,
    input logic [31:0] f);
    chan_io_pkg::sample_t s;
    logic [16:0] v;
    int i;
    v = x;
    if (f[4])
      for (i = 0; i < 17; i++) v[i] = x[16 - i];
    case (f[3:2])
      2'h0: s = {v[16:1], 3'h0};
      2'h1: s = {v[16:3], 2'h0, v[2:0]};
      2'h2: s = {v[16:2], 2'h0, v[1:0]};
      default: s = {v[16:1], 2'h0, v[0]};
    endcase
    s.mant[15] ^= f[11];
    return s;
  endfunction
  function automatic logic [7:0] pick(input logic [3:0] c);
    logic [63:0] ch;
    ch = chan_data_in[c[3]];
    return ch[63 - 8 * c[2:0] -: 8];
  endfunction
  // notes for the four slots; idle buses keep their last word
  task automatic slots;
    logic [10:0] c;
    logic [15:0] d;
    int s;
    for (s = 0; s < 4; s++)
    begin
      c = s[1] ? r23[16 * s[0] +: 11] : r01[16 * s[0] +: 11];
      d = {pick(c[7:4]), pick(c[3:0])} ^ {16{r01[27]}};
      if (c[8]) last_a = d;
      if (c[9]) last_c = d;
      if (c[10]) fq.push_back({30'h0, last_a, c[8], last_c, c[9]});
    end
  endtask
  // result watcher
  always @(posedge clk_in)
  begin
    rd_d <= reg_rd_in;
    if (rd_d) cmp_reg(64'(reg_rdata_out));
    if (sample_valid_out === 1'b1 && mon_on)
      cmp_sample(64'(sample_out));
    if (frame_sync_output_out === 1'b1)
      cmp_slot(64'({first_bus_out, first_bus_sync_pin_out,
        third_bus_out, third_bus_sync_pin_out}));
  end
  // ****************************************
  // run
  // ****************************************
  initial
  begin
    reset_n_in = 1'b0;
    ce_in = 1'b1;
    reg_addr_in = 12'h0;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    chan_data_in = '0;
    chan_new_in = 4'h0;
    mon_on = 1'b0;
    rd_d = 1'b0;
    last_a = 16'h0;
    last_c = 16'h0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(37804));
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // reset values, then all ones incl. an unmapped word
    for (k = 0; k < 4; k++) rd(12'h100 + 12'(k), 32'h0);
    for (k = 0; k < 4; k++) wr(12'h100 + 12'(k), '1);
    rd(chan_io_pkg::OFF_FORMAT, chan_io_pkg::FORMAT_MASK);
    rd(chan_io_pkg::OFF_ROUTE01, chan_io_pkg::ROUTE01_MASK);
    rd(chan_io_pkg::OFF_ROUTE23, chan_io_pkg::ROUTE23_MASK);
    rd(12'h103, 32'h0);
    rd(chan_io_pkg::OFF_STATUS, 32'h0);
    // leave the all-ones format before samples are watched
    wr(chan_io_pkg::OFF_FORMAT, 32'h4000);
    drain;
    mon_on <= 1'b1;
    $display("test registers done");
    // bus clock capture: every mode, both edges, delays 0 to 7, gated
    for (k = 0; k < 8; k++)
    begin
      for (j = 0; j < 8; j++) w[j] = 17'($urandom);
      fmt = {18'h1, k[2], 1'b0, 1'($urandom), 1'b0, k[2:0], 2'h0,
        1'($urandom), k[1:0], 2'h0};
      wr(chan_io_pkg::OFF_FORMAT, fmt);
      sq.push_back(64'(dec(w[k], fmt)));
      conv_model_inst.frame(w, fmt[13]);
      drain;
    end
    // interpolate: enabled word, then one zero sample per capture
    wr(chan_io_pkg::OFF_FORMAT, 32'h4400);
    sq.push_back(64'(dec(w[0], 32'h4400)));
    for (j = 1; j < 8; j++) sq.push_back(64'h0);
    conv_model_inst.frame(w, 1'b0);
    drain;
    $display("test input capture done");
    // common clock: delay 2 counts clk cycles, so it lands on word 1
    mon_on <= 1'b0;
    wr(chan_io_pkg::OFF_FORMAT, 32'h5100);
    conv_model_inst.frame(w, 1'b1);
    repeat (10) @(posedge clk_in);
    check(64'(dec(w[1], 32'h5100)), 64'(sample_out));
    mon_on <= 1'b1;
    $display("test common clock done");
    // slot output per timing source, wrong channel first
    for (k = 0; k < 12; k++)
    begin
      r01 = ($urandom & chan_io_pkg::ROUTE01_MASK) | 32'h400;
      r01[29:28] = k[1:0];
      r23 = $urandom & chan_io_pkg::ROUTE23_MASK;
      for (j = 0; j < 8; j++) cd[j * 32 +: 32] = $urandom;
      chan_data_in <= cd;
      wr(chan_io_pkg::OFF_ROUTE01, r01);
      wr(chan_io_pkg::OFF_ROUTE23, r23);
      rd(chan_io_pkg::OFF_ROUTE01, r01);
      pulse(k[1:0] + 2'h1);
      repeat (8) @(posedge clk_in);
      slots;
      pulse(k[1:0]);
      drain;
    end
    $display("test slot output done");
    close_out;
  end
endmodule
`default_nettype wire
